// ==== src/special_reg_defs.svh ====
`ifndef SPECIAL_REG_DEFS_SVH
`define SPECIAL_REG_DEFS_SVH

// Destination codes of move-to-special.
`define SPR_MACHINE_STATE    16'h0001
`define SPR_FLOAT_STATUS     16'h0007
`define SPR_STACK_LOW        16'h0800
`define SPR_STACK_HIGH       16'h0802
`define SPR_PROCESS_ID       16'h1000
`define SPR_ZONE_PROT        16'h1001
`define SPR_TRANS_INDEX      16'h1002
`define SPR_TRANS_LOW        16'h1003
`define SPR_TRANS_HIGH       16'h1004
`define SPR_TRANS_SEARCH     16'h1005

// State bit positions, counted from the least significant bit.
`define MS_CARRY_POS         2
`define MS_IE_POS            1
`define MS_BIP_POS           3
`define MS_UM_POS            11
`define MS_EIP_POS           9
`define MS_VM_POS            13

// Immediate that touches the carry only.
`define IMM_CARRY_ONLY       15'h0004
// Modifiable immediate width with and without translation.
`define IMM_BITS_MMU         15
`define IMM_BITS_NO_MMU      14

`define CAUSE_PRIVILEGED     5'h07
`define ACK_IE_SET           2'h3
`define ACK_IDLE             2'h0
`define STATE_RESET          32'h0000_0000
`define WORD_RESET           32'h0000_0000

`endif

// ==== src/special_reg_pkg.sv ====
package special_reg_pkg;
	typedef enum logic [1:0] {
		OP_NONE,
		OP_STATE_CLEAR,
		OP_STATE_SET,
		OP_MOVE_TO
	} spr_op_t;

	typedef struct packed {
		logic        valid;
		spr_op_t     op;
		logic [14:0] imm;
		logic [15:0] dest;
		logic        ext;
		logic [31:0] src;
	} spr_req_t;

	typedef struct packed {
		logic        wr_en;
		logic [31:0] data;
		logic        exc;
		logic [4:0]  cause;
	} spr_rsp_t;
endpackage

// ==== src/spr_word_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module spr_word_bank #(
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic          clk_sys,
	input  wire logic          resetn,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [31:0]   wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [31:0]   rd_data
);
	logic [31:0] mem_ff [DEPTH];
	logic [31:0] rd_ff;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= 32'h0000_0000;
			end
			rd_ff <= 32'h0000_0000;
		end else begin
			if (wr_en) begin
				mem_ff[wr_addr] <= wr_data;
			end
			rd_ff <= mem_ff[rd_addr];
		end
	end

	assign rd_data = rd_ff;
endmodule // spr_word_bank
`default_nettype wire

// ==== src/special_reg_move_unit.sv ====
// Contract
// [RQ1] Clear op copies state, clears immediate bits.
// [RQ2] Set op copies state, sets immediate bits.
// [RQ3] User-mode non-carry state op traps, nothing written.
// [RQ4] Carry changes at once, others next cycle.
// [RQ5] Clearing interrupt enable blocks interrupts immediately.
// [RQ6] Setting exception/break progress blocks interrupts, breaks.
// [RQ7] Set op with enable bit acknowledges 11.
// [RQ8] Move to state with enable acknowledges 11.
// [RQ9] Any user-mode move-to-special traps.
// [RQ10] Decode state, float, stack limit destinations.
// [RQ11] Decode the six translation destinations.
// [RQ12] Extended write only to translation low upper part.
// [RQ13] Moved state takes effect next cycle.
// [RQ14] Counter, exception, version registers not writable.
// [RQ15] State ops touch only configured low bits.
// [RQ16] State ops exist only when enabled.
// [RQ17] Translation destinations need configured levels.
// [RQ18] Software spaces state ops after state writers.
// [RQ19] Software avoids state use after move.
// [RQ20] Software syncs after mode or identifier change.
// [RQ21] Software fences after invalidating translation entries.
// [RQ22] Software writes extended part then low part.
// [RQ23] Data barrier waits for outstanding data accesses.
// [RQ24] Undefined or invalid destination does nothing.
`include "special_reg_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module special_reg_move_unit #(
	parameter int cfg_translation_level  = 3,
	parameter int cfg_translation_access = 3,
	parameter int cfg_state_instr_enable = 1,
	parameter int cfg_float_unit         = 1,
	parameter int cfg_stack_guard        = 1,
	parameter int cfg_low_latency_irq    = 1,
	parameter int cfg_phys_addr_ext      = 1
) (
	input  wire logic                      clk_sys,
	input  wire logic                      resetn,
	input  wire special_reg_pkg::spr_req_t req,
	input  wire logic                      barrier_data,
	input  wire logic                      data_outstanding,
	input  wire logic                      irq_in,
	input  wire logic                      break_in,
	input  wire logic [3:0]                bank_rd_sel,
	output special_reg_pkg::spr_rsp_t      rsp,
	output logic                           pipe_stall,
	output logic [1:0]                     interrupt_ack,
	output logic                           irq_take,
	output logic                           break_take,
	output logic [31:0]                    machine_state_reg,
	output logic                           carry_now,
	output logic [31:0]                    bank_rd_data
);
	import special_reg_pkg::*;

	localparam logic [31:0] MASK_MMU   = 32'h0000_7FFF;
	localparam logic [31:0] MASK_NOMMU = 32'h0000_3FFF;
	localparam logic [31:0] STATE_MASK =
		(cfg_translation_level >= 1) ? MASK_MMU : MASK_NOMMU;
	localparam logic [31:0] CARRY_BIT  = 32'h0000_0004;
	localparam logic [31:0] IE_BIT     = 32'h0000_0002;
	localparam logic [31:0] BLOCK_BITS = 32'h0000_0208;

	// ==========================================================
	// Destination decode
	// ==========================================================
	// Returns a bank slot, or 4'hF for an unwritable or absent code.
	function automatic logic [3:0] dest_slot(input logic [15:0] d);
		logic mmu2;
		logic acc2;
		mmu2 = cfg_translation_level > 1;
		acc2 = cfg_translation_access > 1;
		case (d)
			`SPR_FLOAT_STATUS: dest_slot = (cfg_float_unit > 0) ? 4'h0 : 4'hF;
			`SPR_STACK_LOW:  dest_slot = (cfg_stack_guard == 1) ? 4'h1 : 4'hF;
			`SPR_STACK_HIGH: dest_slot = (cfg_stack_guard == 1) ? 4'h2 : 4'hF;
			`SPR_PROCESS_ID: dest_slot = (mmu2 && acc2) ? 4'h3 : 4'hF;
			`SPR_ZONE_PROT:  dest_slot = (mmu2 && acc2) ? 4'h4 : 4'hF;
			`SPR_TRANS_INDEX: dest_slot = mmu2 ? 4'h5 : 4'hF;
			`SPR_TRANS_LOW:  dest_slot = mmu2 ? 4'h6 : 4'hF;
			`SPR_TRANS_HIGH: dest_slot = mmu2 ? 4'h7 : 4'hF;
			`SPR_TRANS_SEARCH: dest_slot = (mmu2 && acc2) ? 4'h8 : 4'hF;
			default: dest_slot = 4'hF;
		endcase
	endfunction

	// ==========================================================
	// State register and exceptions
	// ==========================================================
	logic [31:0] state_ff;
	logic [31:0] nxt_state;
	logic        carry_ff;
	logic        nxt_carry;
	logic        ie_block_ff;
	logic        nxt_ie_block;
	spr_rsp_t    rsp_ff;
	spr_rsp_t    nxt_rsp;
	logic [1:0]  ack_ff;
	logic [1:0]  nxt_ack;
	logic        bank_we;
	logic [3:0]  bank_wa;
	logic [31:0] bank_wd;
	logic        user_mode;
	logic        mmu_on;
	logic        state_op;
	logic [31:0] imm_w;
	logic [3:0]  slot;

	assign user_mode = state_ff[`MS_UM_POS];
	assign mmu_on    = cfg_translation_level >= 1;
	assign state_op  = req.valid && cfg_state_instr_enable == 1 && // RQ16
		(req.op == OP_STATE_CLEAR || req.op == OP_STATE_SET);
	assign imm_w     = {17'h0_0000, req.imm} & STATE_MASK; // RQ15
	assign slot      = dest_slot(req.dest);

	always_comb begin
		nxt_state    = state_ff;
		nxt_carry    = carry_ff;
		nxt_ie_block = 1'b0;
		nxt_rsp      = '0;
		nxt_ack      = `ACK_IDLE;
		bank_we      = 1'b0;
		bank_wa      = 4'h0;
		bank_wd      = req.src;
		if (state_op) begin
			if (mmu_on && user_mode &&
				req.imm != `IMM_CARRY_ONLY) begin
				nxt_rsp.exc   = 1'b1; // RQ3
				nxt_rsp.cause = `CAUSE_PRIVILEGED;
			end else begin
				nxt_rsp.wr_en = 1'b1;
				nxt_rsp.data  = {state_ff[31:3], carry_ff, state_ff[1:0]};
				if (req.op == OP_STATE_CLEAR) begin
					nxt_state = state_ff & ~imm_w; // RQ1
				end else begin
					nxt_state = state_ff | imm_w; // RQ2
					if ((imm_w & IE_BIT) != 32'h0 &&
						cfg_low_latency_irq == 1) begin
						nxt_ack = `ACK_IE_SET; // RQ7
					end
				end
				nxt_carry = nxt_state[`MS_CARRY_POS]; // RQ4
			end
		end else if (req.valid && req.op == OP_MOVE_TO) begin
			if (mmu_on && user_mode) begin
				nxt_rsp.exc   = 1'b1; // RQ9
				nxt_rsp.cause = `CAUSE_PRIVILEGED;
			end else if (req.ext) begin
				if (req.dest == `SPR_TRANS_LOW && slot != 4'hF &&
					cfg_phys_addr_ext == 1) begin
					bank_we = 1'b1; // RQ12
					bank_wa = 4'h9;
				end
			end else if (req.dest == `SPR_MACHINE_STATE) begin
				nxt_state = req.src; // RQ10 RQ13
				nxt_carry = req.src[`MS_CARRY_POS];
				if ((req.src & IE_BIT) != 32'h0 &&
					cfg_low_latency_irq == 1) begin
					nxt_ack = `ACK_IE_SET; // RQ8
				end
			end else if (slot != 4'hF) begin
				bank_we = 1'b1; // RQ10 RQ11 RQ17
				bank_wa = slot;
			end
			// Other codes fall through untouched. // RQ14 RQ24
		end
		// Covers the cycle after the cleared enable is committed.
		if (state_ff[`MS_IE_POS] && !nxt_state[`MS_IE_POS]) begin
			nxt_ie_block = 1'b1; // RQ5
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_ff    <= `STATE_RESET;
			carry_ff    <= 1'b0;
			ie_block_ff <= 1'b0;
			rsp_ff      <= '0;
			ack_ff      <= `ACK_IDLE;
		end else begin
			state_ff    <= nxt_state;
			carry_ff    <= nxt_carry;
			ie_block_ff <= nxt_ie_block;
			rsp_ff      <= nxt_rsp;
			ack_ff      <= nxt_ack;
		end
	end

	// ==========================================================
	// Event gating and outputs
	// ==========================================================
	logic irq_block;
	logic brk_block;

	// Pending new state counts at once so no interrupt slips through.
	assign irq_block = !state_ff[`MS_IE_POS] || !nxt_state[`MS_IE_POS] ||
		ie_block_ff || (nxt_state & BLOCK_BITS) != 32'h0 ||
		(state_ff & BLOCK_BITS) != 32'h0; // RQ5 RQ6
	assign brk_block = (nxt_state & BLOCK_BITS) != 32'h0 ||
		(state_ff & BLOCK_BITS) != 32'h0; // RQ6
	assign irq_take   = irq_in && !irq_block;
	assign break_take = break_in && !brk_block;
	assign pipe_stall = barrier_data && data_outstanding; // RQ23

	assign rsp               = rsp_ff;
	assign interrupt_ack     = ack_ff;
	assign machine_state_reg = {state_ff[31:3], carry_ff, state_ff[1:0]};
	assign carry_now         = nxt_carry; // RQ4

	spr_word_bank #(
		.DEPTH(16),
		.AW   (4)
	) u_bank (
		.clk_sys(clk_sys),
		.resetn (resetn),
		.wr_en  (bank_we),
		.wr_addr(bank_wa),
		.wr_data(bank_wd),
		.rd_addr(bank_rd_sel),
		.rd_data(bank_rd_data)
	);

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_user_state_op;
		state_op && mmu_on && user_mode && req.imm != `IMM_CARRY_ONLY;
	endsequence

	a_priv_state_trap: assert property ( // RQ3
		s_user_state_op |=> rsp.exc && rsp.cause == 5'h07 && !rsp.wr_en &&
		$stable(machine_state_reg))
		else $error("user state op did not trap");
	a_clear_bits: assert property ( // RQ1
		state_op && !(mmu_on && user_mode) && req.op == OP_STATE_CLEAR
		|=> (state_ff & $past(imm_w)) == 32'h0 && rsp.wr_en)
		else $error("clear op left bits set");
	a_set_bits: assert property ( // RQ2
		state_op && !(mmu_on && user_mode) && req.op == OP_STATE_SET
		|=> (state_ff & $past(imm_w)) == $past(imm_w))
		else $error("set op missed bits");
	a_copy_state: assert property ( // RQ2
		state_op && !(mmu_on && user_mode)
		|=> rsp.data == $past(machine_state_reg))
		else $error("copied state wrong");
	a_move_priv: assert property ( // RQ9
		req.valid && req.op == OP_MOVE_TO && mmu_on && user_mode
		|=> rsp.exc && $stable(machine_state_reg))
		else $error("user move did not trap");
	a_ack_move: assert property ( // RQ8
		req.valid && req.op == OP_MOVE_TO && !req.ext && !user_mode &&
		req.dest == 16'h0001 && req.src[1] && cfg_low_latency_irq == 1
		|=> interrupt_ack == 2'h3 ##1
		(interrupt_ack == 2'h0 || $past(req.valid)))
		else $error("missing acknowledge on move");
	a_ack_cause: assert property ( // RQ7
		interrupt_ack == 2'h3 |-> $past(req.valid) &&
		($past(req.op) == OP_STATE_SET || $past(req.op) == OP_MOVE_TO))
		else $error("acknowledge without cause");
	a_move_commit: assert property ( // RQ13
		req.valid && req.op == OP_MOVE_TO && !req.ext && !user_mode &&
		req.dest == 16'h0001 |=> machine_state_reg == $past(req.src))
		else $error("state move not committed");
	a_irq_masked: assert property ( // RQ5
		state_ff[1] && !nxt_state[1] |-> !irq_take ##1 !irq_take)
		else $error("interrupt taken while enable clears");
	a_break_masked: assert property ( // RQ6
		(nxt_state & BLOCK_BITS) != 32'h0 |-> !break_take && !irq_take)
		else $error("break taken while in progress");
	a_barrier_wait: assert property ( // RQ23
		barrier_data && data_outstanding |-> pipe_stall)
		else $error("barrier did not stall");
	a_carry_at_once: assert property ( // RQ4
		state_op && !(mmu_on && user_mode) &&
		({17'h0_0000, req.imm} & CARRY_BIT) != 32'h0
		|-> carry_now == (req.op == OP_STATE_SET))
		else $error("carry did not change at once");

	sequence s_ext_move;
		req.valid && req.op == OP_MOVE_TO && req.ext && !user_mode &&
		cfg_phys_addr_ext == 1 && cfg_translation_level > 1;
	endsequence
	a_ext_low_only: assert property ( // RQ12
		s_ext_move |-> (bank_we && bank_wa == 4'h9) ==
		(req.dest == `SPR_TRANS_LOW))
		else $error("extended part written to wrong place");

	sequence s_dead_move;
		req.valid && req.op == OP_MOVE_TO && !req.ext && !user_mode &&
		req.dest != `SPR_MACHINE_STATE && slot == 4'hF;
	endsequence
	sequence s_nothing_moved;
		!rsp.exc && $stable(machine_state_reg);
	endsequence
	a_bad_dest_quiet: assert property ( // RQ24
		s_dead_move |-> !bank_we ##1 s_nothing_moved)
		else $error("invalid destination changed state");
	a_protected_kept: assert property ( // RQ14
		req.valid && req.op == OP_MOVE_TO && (req.dest inside {16'h0000,
		16'h0003, 16'h0005, 16'h000B, 16'h000D, [16'h2000:16'h200C]})
		|-> !bank_we && nxt_state == state_ff)
		else $error("protected register was written");
endmodule // special_reg_move_unit
`default_nettype wire

// ==== testbench/pipe_issuer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Pipeline side: issues decoded instructions
module pipe_issuer (
	input  wire logic                 clk_sys,
	output special_reg_pkg::spr_req_t req
);
	import special_reg_pkg::*;
	initial req = '0;
	// Every issue waits one edge first, so a bubble always separates
	// a state writer from the next state operation.
	task automatic drive(input spr_op_t o, input logic [14:0] imm,
		input logic [15:0] dest, input logic ext, input logic [31:0] src);
		@(posedge clk_sys);
		#2 req = '{1'b1, o, imm, dest, ext, src};
	endtask
	// Released fields are inverted so stale values are never trusted.
	// The idle slot also stands where the synchronizing branch goes
	// after a mode or identifier change.
	task automatic done();
		@(posedge clk_sys);
		#2 req = {1'b0, ~req[$bits(req)-2:0]};
	endtask
endmodule // pipe_issuer
`default_nettype wire

// ==== testbench/special_reg_move_unit_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module special_reg_move_unit_tb;
	import special_reg_pkg::*;
	typedef struct {
		spr_op_t o; logic [14:0] imm; logic [15:0] dest;
		logic [31:0] src; logic [31:0] st; logic [1:0] ack;
	} row_t;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        barrier_data = 1'b0;
	logic        data_outstanding = 1'b0;
	logic        irq_in = 1'b0;
	logic        break_in = 1'b0;
	logic [3:0]  bank_rd_sel = 4'h0;
	spr_req_t    req;
	spr_rsp_t    rsp;
	logic        pipe_stall, irq_take, break_take, carry_now;
	logic [1:0]  interrupt_ack;
	logic [31:0] machine_state_reg, bank_rd_data, prev;
	int          mismatches = 0;
	int          compares = 0;
	row_t rows[6] = '{
		'{OP_STATE_SET,   15'h0002, 16'h0000, 32'h0, 32'h0000_0002, 2'h3},
		'{OP_STATE_SET,   15'h0208, 16'h0000, 32'h0, 32'h0000_020A, 2'h0},
		'{OP_STATE_CLEAR, 15'h0202, 16'h0000, 32'h0, 32'h0000_0008, 2'h0},
		'{OP_MOVE_TO,     15'h0000, 16'h0001, 32'h6, 32'h0000_0006, 2'h3},
		'{OP_STATE_SET,   15'h77FF, 16'h0000, 32'h0, 32'h0000_77FF, 2'h3},
		'{OP_STATE_CLEAR, 15'h7FFF, 16'h0000, 32'h0, 32'h0000_0000, 2'h0}};
	logic [15:0] dl[9] = '{16'h0007, 16'h0800, 16'h0802, 16'h1000,
		16'h1001, 16'h1002, 16'h1003, 16'h1004, 16'h1005};
	logic [15:0] bad[7] = '{16'h0000, 16'h0003, 16'h0005, 16'h000B,
		16'h000D, 16'h2000, 16'h1006};

	always #12.5 clk_sys = ~clk_sys;

	pipe_issuer u_pipe (.clk_sys(clk_sys), .req(req));
	special_reg_move_unit dut (.clk_sys(clk_sys), .resetn(resetn),
		.req(req), .barrier_data(barrier_data),
		.data_outstanding(data_outstanding), .irq_in(irq_in),
		.break_in(break_in), .bank_rd_sel(bank_rd_sel), .rsp(rsp),
		.pipe_stall(pipe_stall), .interrupt_ack(interrupt_ack),
		.irq_take(irq_take), .break_take(break_take),
		.machine_state_reg(machine_state_reg), .carry_now(carry_now),
		.bank_rd_data(bank_rd_data));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic op(input spr_op_t o, input logic [14:0] imm,
		input logic [15:0] dest, input logic ext, input logic [31:0] src);
		u_pipe.drive(o, imm, dest, ext, src);
		u_pipe.done();
	endtask
	task automatic rd(input logic [3:0] sel, input logic [31:0] exp);
		bank_rd_sel = sel;
		@(posedge clk_sys);
		#2 chk(bank_rd_data, exp);
	endtask

	initial begin
		#125000;
		mismatches++;
		final_report();
	end

	// ==========================================
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_sys);
		#2 chk(machine_state_reg, 32'h0);
		resetn = 1'b1;
		foreach (rows[i]) begin
			prev = machine_state_reg;
			op(rows[i].o, rows[i].imm, rows[i].dest, 1'b0, rows[i].src);
			chk(32'(rsp.wr_en), 32'(rows[i].o != OP_MOVE_TO));
			if (rows[i].o != OP_MOVE_TO) chk(rsp.data, prev);
			chk(machine_state_reg, rows[i].st);
			chk(32'(interrupt_ack), 32'(rows[i].ack));
		end
		u_pipe.drive(OP_STATE_SET, 15'h0006, 16'h0, 1'b0, 32'h0);
		#1 chk(32'(carry_now), 32'h1);
		chk(machine_state_reg, 32'h0);
		u_pipe.done();
		chk(machine_state_reg, 32'h6);
		foreach (dl[i]) op(OP_MOVE_TO, 15'h0, dl[i], 1'b0, 32'hA500_0000 + i);
		{barrier_data, data_outstanding} = 2'h3;
		#1 chk(32'(pipe_stall), 32'h1);
		@(posedge clk_sys);
		#2 {barrier_data, data_outstanding} = 2'h0;
		foreach (dl[i]) rd(4'(i), 32'hA500_0000 + i);
		op(OP_MOVE_TO, 15'h0, 16'h1003, 1'b1, 32'h5A5A_0001);
		op(OP_MOVE_TO, 15'h0, 16'h1003, 1'b0, 32'hA500_0006);
		op(OP_MOVE_TO, 15'h0, 16'h1004, 1'b1, 32'h5A5A_0002);
		rd(4'h9, 32'h5A5A_0001);
		foreach (bad[i]) begin
			op(OP_MOVE_TO, 15'h0, bad[i], 1'b0, 32'hFFFF_FFFF);
			chk(32'(rsp.exc), 32'h0);
		end
		chk(machine_state_reg, 32'h6);
		foreach (dl[i]) rd(4'(i), 32'hA500_0000 + i);
		irq_in = 1'b1;
		break_in = 1'b1;
		@(posedge clk_sys);
		#2 chk(32'(irq_take), 32'h1);
		chk(32'(break_take), 32'h1);
		u_pipe.drive(OP_STATE_CLEAR, 15'h0002, 16'h0, 1'b0, 32'h0);
		#1 chk(32'(irq_take), 32'h0);
		u_pipe.done();
		chk(32'(irq_take), 32'h0);
		op(OP_STATE_SET, 15'h0002, 16'h0, 1'b0, 32'h0);
		u_pipe.drive(OP_STATE_SET, 15'h0008, 16'h0, 1'b0, 32'h0);
		#1 chk(32'({irq_take, break_take}), 32'h0);
		u_pipe.done();
		chk(32'({irq_take, break_take}), 32'h0);
		irq_in = 1'b0;
		break_in = 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			#2 {barrier_data, data_outstanding} = i[1:0];
			#1 chk(32'(pipe_stall), 32'(i == 3));
		end
		@(posedge clk_sys);
		#2 {barrier_data, data_outstanding} = 2'h0;
		op(OP_MOVE_TO, 15'h0, 16'h0001, 1'b0, 32'h0000_0800);
		op(OP_STATE_SET, 15'h0004, 16'h0, 1'b0, 32'h0);
		chk(32'(rsp.exc), 32'h0);
		chk(machine_state_reg, 32'h0000_0804);
		op(OP_STATE_SET, 15'h0002, 16'h0, 1'b0, 32'h0);
		chk(32'({rsp.exc, rsp.cause, rsp.wr_en}), 32'h4E);
		chk(32'(interrupt_ack), 32'h0);
		chk(machine_state_reg, 32'h0000_0804);
		op(OP_MOVE_TO, 15'h0, 16'h0800, 1'b0, 32'h0);
		chk(32'({rsp.exc, rsp.cause}), 32'h27);
		chk(machine_state_reg, 32'h0000_0804);
		rd(4'h1, 32'hA500_0001);
		resetn = 1'b0;
		repeat (2) @(posedge clk_sys);
		#2 chk(machine_state_reg, 32'h0);
		chk(32'(interrupt_ack), 32'h0);
		final_report();
	end
endmodule // special_reg_move_unit_tb
`default_nettype wire
